// File: hdl/pab_defines.vh
/*
 constants for the pipelined converter digital back end.
 assumes inclusion by bare name from the design files.
*/
`ifndef PAB_DEFINES_VH
`define PAB_DEFINES_VH
`define PAB_STAGE_BITS 4
`define PAB_NUM_SUB 4
`define PAB_RES_BITS 14
`define PAB_ALIGN_BITS 20
`define PAB_LATENCY 4
`define PAB_STAGE_SHIFT 3
`define PAB_PH_SAMPLE 2'h0
`define PAB_PH_GAP1 2'h1
`define PAB_PH_HOLD 2'h2
`define PAB_PH_GAP2 2'h3
`endif

// File: hdl/pab_delay_line.v
/*
 delay line: holds one stage word for a number of sample clock cycles.
 assumes the advance strobe (the sample tick) comes from the same clock domain.
*/
`timescale 1ns/1ps
`include "pab_defines.vh"
module pab_delay_line #(
    parameter WIDTH = 4,
    parameter DEPTH = 1
) (
    input wire mclk_i,
    input wire srst_i,
    input wire adv_i,
    input wire [WIDTH-1:0] din_i,
    output wire [WIDTH-1:0] dout_o
);
    // one register per tap, chained through a wire so each has one driver
    wire [WIDTH*(DEPTH+1)-1:0] chain_w;
    assign chain_w[WIDTH-1:0] = din_i;
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_tap
            reg [WIDTH-1:0] tap_reg;
            always @(posedge mclk_i) begin
                if (srst_i) begin
                    tap_reg <= {WIDTH{1'b0}};
                end else if (adv_i) begin
                    tap_reg <= chain_w[g*WIDTH +: WIDTH];
                end
            end
            assign chain_w[(g+1)*WIDTH +: WIDTH] = tap_reg;
        end
    endgenerate
    assign dout_o = chain_w[DEPTH*WIDTH +: WIDTH];
endmodule // pab_delay_line

// File: hdl/pab_backend.v
/*
 digital back end of a 14-bit pipelined converter: two-phase clock,
 stage word alignment, error correction and output latch.
 assumes stage words arrive synchronous to mclk_i from the analog core;
 mclk_i is the master sampling clock, four mclk_i ticks per conversion phase pair.
*/
`timescale 1ns/1ps
`include "pab_defines.vh"
module pab_backend #(
    parameter SW = `PAB_STAGE_BITS,
    parameter RW = `PAB_RES_BITS
) (
    input wire mclk_i,
    input wire srst_i,
    input wire [SW-1:0] stage1_word_i,
    input wire [SW-1:0] stage2_word_i,
    input wire [SW-1:0] stage3_word_i,
    input wire [SW-1:0] stage4_word_i,
    input wire [SW-1:0] flash_word_i,
    output wire phase_sample_o,
    output wire phase_hold_o,
    output wire [`PAB_NUM_SUB-1:0] stage_sample_o,
    output wire [`PAB_NUM_SUB-1:0] stage_amp_o,
    output wire sample_tick_o,
    output wire [RW-1:0] result_o,
    output wire result_bit_msb_o,
    output wire result_bit_lsb_o
);
    ////////////////////////////////////////////////////////////////////////////
    // two-phase clock with dead gaps so phases never overlap
    reg [1:0] phase_reg;
    reg [1:0] phase_next;
    always @* begin
        case (phase_reg)
            `PAB_PH_SAMPLE: phase_next = `PAB_PH_GAP1;
            `PAB_PH_GAP1: phase_next = `PAB_PH_HOLD;
            `PAB_PH_HOLD: phase_next = `PAB_PH_GAP2;
            `PAB_PH_GAP2: phase_next = `PAB_PH_SAMPLE;
            default: phase_next = `PAB_PH_SAMPLE;
        endcase
    end
    always @(posedge mclk_i) begin
        if (srst_i) begin
            phase_reg <= `PAB_PH_SAMPLE;
        end else begin
            phase_reg <= phase_next;
        end
    end
    assign phase_sample_o = (phase_reg == `PAB_PH_SAMPLE);
    assign phase_hold_o = (phase_reg == `PAB_PH_HOLD);
    // a conversion cycle ends at the last gap; one sample per cycle
    wire tick = (phase_reg == `PAB_PH_GAP2);
    assign sample_tick_o = tick;
    ////////////////////////////////////////////////////////////////////////////
    // per stage phase assignment, alternating stages swapped
    genvar s;
    generate
        for (s = 0; s < `PAB_NUM_SUB; s = s + 1) begin : g_stage
            if (s % 2 == 0) begin : g_even
                assign stage_sample_o[s] = phase_sample_o;
                assign stage_amp_o[s] = phase_hold_o;
            end else begin : g_odd
                assign stage_sample_o[s] = phase_hold_o;
                assign stage_amp_o[s] = phase_sample_o;
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////
    // alignment: earlier stages wait longer for the flash stage
    wire [SW-1:0] al1, al2, al3, al4, al5;
    pab_delay_line #(.WIDTH(SW), .DEPTH(`PAB_LATENCY)) u_dl1 (
        .mclk_i(mclk_i), .srst_i(srst_i), .adv_i(tick), .din_i(stage1_word_i), .dout_o(al1));
    pab_delay_line #(.WIDTH(SW), .DEPTH(`PAB_LATENCY-1)) u_dl2 (
        .mclk_i(mclk_i), .srst_i(srst_i), .adv_i(tick), .din_i(stage2_word_i), .dout_o(al2));
    pab_delay_line #(.WIDTH(SW), .DEPTH(`PAB_LATENCY-2)) u_dl3 (
        .mclk_i(mclk_i), .srst_i(srst_i), .adv_i(tick), .din_i(stage3_word_i), .dout_o(al3));
    pab_delay_line #(.WIDTH(SW), .DEPTH(`PAB_LATENCY-3)) u_dl4 (
        .mclk_i(mclk_i), .srst_i(srst_i), .adv_i(tick), .din_i(stage4_word_i), .dout_o(al4));
    assign al5 = flash_word_i;
    wire [`PAB_ALIGN_BITS-1:0] aligned_w = {al1, al2, al3, al4, al5};
    ////////////////////////////////////////////////////////////////////////////
    // correction: stage words overlap by one redundant bit each; add
    // each word shifted by three bits so the redundancy absorbs errors
    wire [RW+1:0] sum_w = ({2'h0, aligned_w[19:16], 10'h000} +
                           {5'h00, aligned_w[15:12], 7'h00} +
                           {8'h00, aligned_w[11:8], 4'h0} +
                           {11'h000, aligned_w[7:4], 1'h0} +
                           {14'h0000, aligned_w[3:2]});
    // clip overflow beyond full scale, limitation: no over-range flag
    wire [RW-1:0] corr_w = sum_w[RW+1:RW] != 2'h0 ? {RW{1'b1}} : sum_w[RW-1:0];
    // offset binary to two's complement: flip msb
    wire [RW-1:0] tc_w = {~corr_w[RW-1], corr_w[RW-2:0]};
    ////////////////////////////////////////////////////////////////////////////
    // output latch, updated once per sample clock
    reg [RW-1:0] out_reg;
    always @(posedge mclk_i) begin
        if (srst_i) begin
            out_reg <= {RW{1'b0}};
        end else if (tick) begin
            out_reg <= tc_w;
        end
    end
    assign result_o = out_reg;
    assign result_bit_msb_o = out_reg[RW-1];
    assign result_bit_lsb_o = out_reg[0];
endmodule // pab_backend

// File: dv/pab_backend_checker.sv
/*
 checker: phase, tick and result relations of the back end.
 assumes a bind to pab_backend and a sync reset, high.
*/
`timescale 1ns/1ps
module pab_backend_checker (
    input wire mclk_i,
    input wire srst_i,
    input wire phase_sample_o,
    input wire phase_hold_o,
    input wire [3:0] stage_sample_o,
    input wire [3:0] stage_amp_o,
    input wire sample_tick_o,
    input wire [13:0] result_o,
    input wire result_bit_msb_o,
    input wire result_bit_lsb_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (srst_i);
////////////////////////////////////////////////////////////////
sequence s_quiet3; !sample_tick_o [*3]; endsequence
sequence s_gap_hold; !phase_hold_o ##1 phase_hold_o; endsequence
chk_no_overlap: assert property (!(phase_sample_o && phase_hold_o)) else $error("phases overlap");
chk_tick_period: assert property (sample_tick_o |=> s_quiet3 ##1 sample_tick_o) else $error("tick spacing");
chk_tick_gap: assert property (sample_tick_o |-> !phase_sample_o && !phase_hold_o) else $error("tick in phase");
chk_sample_next: assert property (sample_tick_o |=> phase_sample_o) else $error("no sample phase");
chk_hold_order: assert property (phase_sample_o |=> s_gap_hold) else $error("hold phase order");
chk_stage_alt: assert property ((phase_sample_o || phase_hold_o) |-> (stage_sample_o[0] != stage_sample_o[1])
    && (stage_sample_o[2] == stage_sample_o[0]) && (stage_sample_o[3] == stage_sample_o[1])) else $error("alt");
chk_amp_excl: assert property ((stage_sample_o & stage_amp_o) == 4'h0) else $error("sample and amp");
chk_result_hold: assert property (!sample_tick_o |=> $stable(result_o)) else $error("result moved");
chk_bit_map: assert property ({result_bit_msb_o, result_bit_lsb_o} == {result_o[13], result_o[0]})
    else $error("bit lines");
endmodule // pab_backend_checker
bind pab_backend pab_backend_checker i_chk (.mclk_i(mclk_i), .srst_i(srst_i), .phase_sample_o(phase_sample_o),
    .phase_hold_o(phase_hold_o), .stage_sample_o(stage_sample_o), .stage_amp_o(stage_amp_o),
    .sample_tick_o(sample_tick_o), .result_o(result_o), .result_bit_msb_o(result_bit_msb_o),
    .result_bit_lsb_o(result_bit_lsb_o));

// File: dv/pab_capture_model.sv
/*
 capture model: downstream logic latching the result bus once per sample clock.
 assumes tick and bus come from the back end in the same clock domain.
*/
`timescale 1ns/1ps
module pab_capture_model (
    input wire mclk_i,
    input wire srst_i,
    input wire tick_i,
    input wire [13:0] data_i,
    output reg [13:0] word_o,
    output reg valid_o
);
reg tick_d_reg;
reg [2:0] count_reg;
// capture a cycle after the tick, while the word stands
always @(posedge mclk_i) begin
    tick_d_reg <= tick_i && !srst_i;
    if (srst_i) begin
        count_reg <= 3'h0;
        valid_o <= 1'b0;
    end else if (tick_d_reg) begin
        word_o <= data_i;
        valid_o <= (count_reg == 3'h4);
        count_reg <= (count_reg == 3'h4) ? count_reg : count_reg + 3'h1;
    end
end
endmodule // pab_capture_model

// File: dv/pab_backend_tb.sv
/*
 bench for the back end: drives stage words, judges captured results.
 assumes a 10 MHz clock and a sync reset, high.
*/
`timescale 1ns/1ps
module pab_backend_tb;
reg mclk_i = 1'b0;
reg srst_i = 1'b1;
reg [3:0] s1 = 4'h0, s2 = 4'h0, s3 = 4'h0, s4 = 4'h0, fl = 4'h0;
wire [13:0] result, cap_word;
wire tick, cap_valid, msb, lsb;
integer failures = 0, checks_done = 0, cycles = 0, i, n;
reg [33:0] v;
pab_backend i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .stage1_word_i(s1), .stage2_word_i(s2), .stage3_word_i(s3),
    .stage4_word_i(s4), .flash_word_i(fl), .phase_sample_o(), .phase_hold_o(), .stage_sample_o(),
    .stage_amp_o(), .sample_tick_o(tick), .result_o(result), .result_bit_msb_o(msb), .result_bit_lsb_o(lsb));
pab_capture_model i_cap (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick), .data_i(result),
    .word_o(cap_word), .valid_o(cap_valid));
initial forever #50 mclk_i = ~mclk_i;
////////////////////////////////////////////////////////////////
task check(input [13:0] got, input [13:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
// wait past a tick edge and the capture edge after it
task next_cap;
    begin
        @(negedge mclk_i);
        while (tick !== 1'b1) @(negedge mclk_i);
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
    end
endtask
task t_codes;
    for (i = 0; i < 4; i = i + 1) begin
        case (i)
            0: v = {20'h00000, 14'h2000};
            1: v = {20'h80000, 14'h0000};
            2: v = {20'hfffff, 14'h1fff};
            default: v = {20'h3579c, 14'h2f05};
        endcase
        {s1, s2, s3, s4, fl} = v[33:14];
        repeat (5) next_cap;
        check(cap_word, v[13:0]);
        check({12'h0, msb, lsb}, {12'h0, v[13], v[0]});
        check({13'h0, cap_valid}, 14'h0001);
    end
endtask
// stage one word reaches the bus on the fifth sample clock
task t_latency;
    begin
        s1 = 4'h8;
        for (n = 1; n < 6; n = n + 1) begin
            next_cap;
            check(cap_word, (n < 5) ? 14'h2f05 : 14'h0305);
        end
    end
endtask
task results;
    begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
        failures = failures + 1;
        results;
    end
end
initial begin
    repeat (16) @(negedge mclk_i);
    srst_i = 1'b0;
    t_codes;
    $display("codes test ended");
    t_latency;
    $display("latency test ended");
    results;
end
endmodule // pab_backend_tb
